/* src/bus_seq_pkg.sv */
package bus_seq_pkg;
    // ========================================
    // Protocol sizes
    localparam int ADDR_BITS = 16;
    localparam int BYTE_BITS = 8;
    localparam int PAGE_BYTES = 32;
    localparam logic [5:0] PAGE_MAX = 6'h20;
    localparam logic [4:0] BIT_LAST_ADDR = 5'h0f;
    localparam logic [4:0] BIT_LAST_BYTE = 5'h07;
    // ========================================
    // Bus cycle timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int STROBE_NS = 50;
    localparam int SETUP_NS = 25;
    localparam logic [3:0] STROBE_CYC = 4'((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] SETUP_CYC = 4'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // ========================================
    // Commands and cycle kinds
    typedef enum logic [1:0] {CMD_READ, CMD_WRITE, CMD_STATUS} cmd_e;
    typedef enum logic [1:0] {CYC_READ, CYC_WRITE} cyc_e;
    localparam logic [1:0] CYC_NONE = 2'h3;
endpackage : bus_seq_pkg

/* src/bus_cycle.sv */
`timescale 1ns/1ps
`default_nettype none
module bus_cycle
    import bus_seq_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Request
    input wire logic go,
    input wire logic is_write,
    input wire logic bit_out,
    output logic done,
    output logic bit_in,
    // Pins
    output logic chip_select_n,
    output logic write_strobe_n,
    output logic output_drive_n,
    output logic line_out,
    output logic line_oe,
    input wire logic line_in
);
    // ========================================
    // Single bus cycle: setup, strobe, release
    typedef enum {CY_IDLE, CY_SETUP, CY_STROBE, CY_END} cy_e;
    cy_e st_q, st_d;
    logic [3:0] cnt_q, cnt_d;
    logic wr_q, wr_d, dat_q, dat_d, in_q, in_d;
    logic cs_d, we_d, oe_d, oen_d, done_d;

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        wr_d = wr_q;
        dat_d = dat_q;
        in_d = in_q;
        cs_d = 1'b1;
        we_d = 1'b1;
        oe_d = 1'b1;
        oen_d = 1'b0;
        done_d = 1'b0;
        unique case (st_q)
            CY_IDLE: begin
                if (go) begin
                    st_d = CY_SETUP;
                    wr_d = is_write;
                    dat_d = bit_out;
                    cnt_d = SETUP_CYC;
                end
            end
            CY_SETUP: begin
                cs_d = 1'b0;
                oen_d = wr_q;
                cnt_d = cnt_q - 4'h1;
                if (cnt_q == 4'h1) begin
                    st_d = CY_STROBE;
                    cnt_d = STROBE_CYC;
                end
            end
            CY_STROBE: begin
                cs_d = 1'b0;
                oen_d = wr_q;
                we_d = ~wr_q;
                oe_d = wr_q;
                cnt_d = cnt_q - 4'h1;
                if (cnt_q == 4'h1) begin
                    st_d = CY_END;
                    if (!wr_q) in_d = line_in;
                end
            end
            CY_END: begin
                // Strobe rises first, data held on wire
                cs_d = 1'b0;
                oen_d = wr_q;
                done_d = 1'b1;
                st_d = CY_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_q <= CY_IDLE;
            cnt_q <= 4'h0;
            wr_q <= 1'b0;
            dat_q <= 1'b0;
            in_q <= 1'b1;
            chip_select_n <= 1'b1;
            write_strobe_n <= 1'b1;
            output_drive_n <= 1'b1;
            line_oe <= 1'b0;
            line_out <= 1'b0;
            done <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            wr_q <= wr_d;
            dat_q <= dat_d;
            in_q <= in_d;
            chip_select_n <= cs_d;
            write_strobe_n <= we_d;
            output_drive_n <= oe_d;
            line_oe <= oen_d;
            line_out <= dat_d;
            done <= done_d;
        end
    end
    assign bit_in = in_q;

    chk_strobe_excl: assert property (@(posedge core_clk) disable iff (rst)
        !(!write_strobe_n && !output_drive_n)) else $error("both strobes low");
    chk_write_drive: assert property (@(posedge core_clk) disable iff (rst)
        !write_strobe_n |-> line_oe && !chip_select_n) else $error("write without drive");
endmodule : bus_cycle
`default_nettype wire

/* src/eeprom_host.sv */
`timescale 1ns/1ps
`default_nettype none
module eeprom_host
    import bus_seq_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Command port
    input wire logic cmd_valid,
    input wire logic [1:0] cmd_op,
    input wire logic [15:0] cmd_addr,
    input wire logic [5:0] cmd_len,
    output logic cmd_ready,
    // Write data request
    output logic wdata_req,
    input wire logic [7:0] wdata,
    // Read data answer
    output logic rdata_valid,
    output logic [7:0] rdata,
    output logic busy_status,
    // Device pins
    output logic chip_select_n,
    output logic write_strobe_n,
    output logic output_drive_n,
    output logic line_out,
    output logic line_oe,
    input wire logic line_in
);
    // ========================================
    // Sequencer
    typedef enum {S_IDLE, S_RST_R1, S_RST_W0, S_RST_R2, S_ADDR, S_WDAT, S_RDAT,
        S_END_W1, S_NV_R1, S_NV_W1, S_NV_R2, S_STAT} seq_e;
    seq_e st_q, st_d;
    cmd_e op_q, op_d;
    logic [15:0] addr_q, addr_d;
    logic [7:0] sh_q, sh_d;
    logic [4:0] bit_q, bit_d;
    logic [5:0] left_q, left_d;
    logic go_q, go_d, wait_q, wait_d;
    logic cyc_wr, cyc_bit, cyc_done, cyc_in;
    logic rv_d, ready_d, req_d, busy_d;
    logic [7:0] rd_d;

    bus_cycle u_cycle (
        .core_clk(core_clk),
        .rst(rst),
        .go(go_q),
        .is_write(cyc_wr),
        .bit_out(cyc_bit),
        .done(cyc_done),
        .bit_in(cyc_in),
        .chip_select_n(chip_select_n),
        .write_strobe_n(write_strobe_n),
        .output_drive_n(output_drive_n),
        .line_out(line_out),
        .line_oe(line_oe),
        .line_in(line_in)
    );

    function automatic logic st_is_write(input seq_e s);
        return s inside {S_RST_W0, S_ADDR, S_WDAT, S_END_W1, S_NV_W1};
    endfunction

    always_comb begin
        cyc_wr = st_is_write(st_q);
        unique case (st_q)
            S_RST_W0: cyc_bit = 1'b0;
            S_ADDR: cyc_bit = addr_q[ADDR_BITS - 1];
            S_WDAT: cyc_bit = sh_q[BYTE_BITS - 1];
            default: cyc_bit = 1'b1;
        endcase
    end

    always_comb begin
        st_d = st_q;
        op_d = op_q;
        addr_d = addr_q;
        sh_d = sh_q;
        bit_d = bit_q;
        left_d = left_q;
        go_d = 1'b0;
        wait_d = wait_q;
        rv_d = 1'b0;
        req_d = 1'b0;
        rd_d = rdata;
        busy_d = busy_status;
        ready_d = 1'b0;
        if (st_q == S_IDLE) begin
            ready_d = !cmd_valid;
            if (cmd_valid && cmd_ready) begin
                op_d = cmd_e'(cmd_op);
                addr_d = cmd_addr;
                left_d = (cmd_len == 6'h0 || cmd_len > PAGE_MAX) ? 6'h1 : cmd_len;
                st_d = (cmd_op == CMD_STATUS) ? S_STAT : S_RST_R1;
                go_d = 1'b1;
                bit_d = 5'h0;
            end
        end else if (wait_q) begin
            // Next cycle of the sequence
            go_d = 1'b1;
            wait_d = 1'b0;
        end else if (cyc_done) begin
            wait_d = 1'b1;
            unique case (st_q)
                S_RST_R1: st_d = S_RST_W0;
                S_RST_W0: st_d = S_RST_R2;
                S_RST_R2: st_d = S_ADDR;
                S_ADDR: begin
                    addr_d = {addr_q[ADDR_BITS - 2:0], addr_q[ADDR_BITS - 1]};
                    bit_d = bit_q + 5'h1;
                    if (bit_q == BIT_LAST_ADDR) begin
                        bit_d = 5'h0;
                        st_d = (op_q == CMD_WRITE) ? S_WDAT : S_RDAT;
                        if (op_q == CMD_WRITE) begin
                            sh_d = wdata;
                            req_d = 1'b1;
                        end
                    end
                end
                S_WDAT: begin
                    sh_d = {sh_q[BYTE_BITS - 2:0], 1'b0};
                    bit_d = bit_q + 5'h1;
                    if (bit_q == BIT_LAST_BYTE) begin
                        bit_d = 5'h0;
                        left_d = left_q - 6'h1;
                        if (left_q == 6'h1) begin
                            st_d = S_NV_R1;
                        end else begin
                            sh_d = wdata;
                            req_d = 1'b1;
                        end
                    end
                end
                S_RDAT: begin
                    sh_d = {sh_q[BYTE_BITS - 2:0], cyc_in};
                    bit_d = bit_q + 5'h1;
                    if (bit_q == BIT_LAST_BYTE) begin
                        bit_d = 5'h0;
                        rv_d = 1'b1;
                        rd_d = {sh_q[BYTE_BITS - 2:0], cyc_in};
                        left_d = left_q - 6'h1;
                        if (left_q == 6'h1) st_d = S_END_W1;
                    end
                end
                S_NV_R1: st_d = S_NV_W1;
                S_NV_W1: st_d = S_NV_R2;
                S_NV_R2: begin
                    st_d = S_IDLE;
                    wait_d = 1'b0;
                    busy_d = 1'b1;
                end
                S_STAT: begin
                    busy_d = ~cyc_in;
                    st_d = S_IDLE;
                    wait_d = 1'b0;
                end
                default: begin
                    st_d = S_IDLE;
                    wait_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_q <= S_IDLE;
            op_q <= CMD_READ;
            addr_q <= 16'h0000;
            sh_q <= 8'h00;
            bit_q <= 5'h00;
            left_q <= 6'h00;
            go_q <= 1'b0;
            wait_q <= 1'b0;
            cmd_ready <= 1'b0;
            wdata_req <= 1'b0;
            rdata_valid <= 1'b0;
            rdata <= 8'h00;
            busy_status <= 1'b0;
        end else begin
            st_q <= st_d;
            op_q <= op_d;
            addr_q <= addr_d;
            sh_q <= sh_d;
            bit_q <= bit_d;
            left_q <= left_d;
            go_q <= go_d;
            wait_q <= wait_d;
            cmd_ready <= ready_d;
            wdata_req <= req_d;
            rdata_valid <= rv_d;
            rdata <= rd_d;
            busy_status <= busy_d;
        end
    end

    // ========================================
    // Checks
    sequence s_go;
        go_q;
    endsequence
    sequence s_done_in_8;
        ##[1:8] cyc_done;
    endsequence
    chk_cycle_done: assert property (@(posedge core_clk) disable iff (rst)
        s_go |-> s_done_in_8) else $error("cycle did not finish");
    chk_reset_order: assert property (@(posedge core_clk) disable iff (rst)
        st_q == S_RST_R1 && cyc_done |=> st_q == S_RST_W0) else $error("reset order");
    // Address goes to data after 16
    chk_addr_count: assert property (@(posedge core_clk) disable iff (rst)
        st_q == S_ADDR |-> bit_q <= BIT_LAST_ADDR) else $error("address count");
    chk_byte_count: assert property (@(posedge core_clk) disable iff (rst)
        st_q inside {S_RDAT, S_WDAT} |-> bit_q <= BIT_LAST_BYTE) else $error("byte count");
    chk_page_len: assert property (@(posedge core_clk) disable iff (rst)
        st_q == S_WDAT |-> left_q != 6'h0 && left_q <= PAGE_MAX) else $error("page length");
    chk_nv_order: assert property (@(posedge core_clk) disable iff (rst)
        st_q == S_NV_W1 && cyc_done |=> st_q == S_NV_R2) else $error("program order");
endmodule : eeprom_host
`default_nettype wire

/* testbench/nv_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module nv_mem_model #(
    parameter int PROG_NS = 20000
) (
    // Device pins
    input wire logic chip_select_n,
    input wire logic write_strobe_n,
    input wire logic output_drive_n,
    input wire logic nv_lock_n,
    // Shared data line
    input wire logic host_out,
    input wire logic host_oe,
    output logic line,
    output logic dev_oe
);
    typedef enum logic [2:0] {ST_IDLE, ST_RST, ST_ADDR, ST_RD, ST_LOAD, ST_LEND, ST_ARM} mstate_e;
    logic [7:0] mem [0:65535];
    logic [7:0] page [0:31];
    logic [31:0] loaded = '0;
    mstate_e st = ST_IDLE;
    logic [15:0] addr = 16'h0000;
    logic [7:0] sh = 8'h00;
    int cnt = 0;
    logic wel = 1'b0, busy = 1'b0, prev_rd = 1'b0, wr_pend = 1'b0, rd_on = 1'b0, dev_bit = 1'b1;
    // ========================================
    // Array contents and line
    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h5a;
        end
    end
    assign dev_oe = !chip_select_n && !output_drive_n;
    assign line = host_oe ? host_out : (dev_oe ? dev_bit : ~dev_bit);
    // ========================================
    // Protocol
    task automatic drop();
        st = ST_IDLE;
        wel = 1'b0;
    endtask : drop
    task automatic on_write(input logic b);
        if (busy) begin
        end else if (st == ST_ADDR && cnt < 16) begin
            addr = {addr[14:0], b};
            cnt++;
        end else if (prev_rd && !b) begin
            st = ST_RST;
            wel = nv_lock_n;
            cnt = 0;
            loaded = '0;
        end else if (prev_rd && b && st == ST_LEND && cnt == 0) begin
            st = ST_ARM;
        end else if (prev_rd || st == ST_RST || st == ST_ARM || st == ST_LEND) begin
            drop();
        end else if (st == ST_ADDR || st == ST_LOAD) begin
            if (st == ST_ADDR) begin
                st = ST_LOAD;
                cnt = 0;
            end
            sh = {sh[6:0], b};
            cnt++;
            if (cnt == 8) begin
                page[addr[4:0]] = sh;
                loaded[addr[4:0]] = 1'b1;
                addr[4:0] = addr[4:0] + 5'h01;
                cnt = 0;
            end
        end
        prev_rd = 1'b0;
    endtask : on_write
    task automatic on_read();
        if (busy) begin
            dev_bit = 1'b0;
        end else if (st == ST_RD || (st == ST_ADDR && cnt == 16)) begin
            if (st == ST_ADDR) begin
                st = ST_RD;
                cnt = 0;
            end
            dev_bit = mem[addr][7 - cnt];
            cnt++;
            if (cnt == 8) begin
                cnt = 0;
                addr++;
            end
        end else begin
            dev_bit = 1'b1;
            if (st == ST_LOAD) begin
                st = ST_LEND;
            end else if (st == ST_ARM && wel && nv_lock_n && loaded != '0) begin
                busy = 1'b1;
                dev_bit = 1'b0;
            end else if (st == ST_RST) begin
                st = ST_ADDR;
            end else if (!(st == ST_ADDR && cnt == 0)) begin
                drop();
            end
        end
        prev_rd = 1'b1;
    endtask : on_read
    // ========================================
    // Pin events
    always @(negedge write_strobe_n) if (!chip_select_n) wr_pend = 1'b1;
    always @(negedge chip_select_n) if (!write_strobe_n) wr_pend = 1'b1;
    always @(posedge write_strobe_n or posedge chip_select_n) begin
        if (wr_pend) begin
            wr_pend = 1'b0;
            on_write(line);
        end
    end
    always @(output_drive_n or chip_select_n) begin
        if (!chip_select_n && !output_drive_n && !rd_on) on_read();
        rd_on = !chip_select_n && !output_drive_n;
    end
    always @(negedge nv_lock_n) wel = 1'b0;
    always @(posedge busy) begin
        #(PROG_NS);
        for (int i = 0; i < 32; i++) begin
            if (loaded[i]) mem[{addr[15:5], 5'(i)}] = page[i];
        end
        busy = 1'b0;
        wel = 1'b0;
        st = ST_IDLE;
    end
endmodule : nv_mem_model
`default_nettype wire

/* testbench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import bus_seq_pkg::*;
    logic core_clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, nv_lock_n = 1'b1, req_seen = 1'b0;
    logic [1:0] cmd_op = 2'h0;
    logic [15:0] cmd_addr = 16'h0000;
    logic [5:0] cmd_len = 6'h01;
    logic [7:0] wbuf [0:31];
    logic [7:0] wdata, rdata;
    logic cmd_ready, wdata_req, rdata_valid, busy_status, chip_select_n, write_strobe_n;
    logic output_drive_n, line_out, line_oe, line_in, dev_oe;
    logic [7:0] rq [$];
    int widx = 0, failures = 0, n_checks = 0;
    // ========================================
    // Block and device
    eeprom_host uut (.core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_addr(cmd_addr), .cmd_len(cmd_len), .cmd_ready(cmd_ready), .wdata_req(wdata_req),
        .wdata(wdata), .rdata_valid(rdata_valid), .rdata(rdata), .busy_status(busy_status),
        .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n), .output_drive_n(output_drive_n),
        .line_out(line_out), .line_oe(line_oe), .line_in(line_in));
    nv_mem_model #(.PROG_NS(20000)) dev (.chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n),
        .output_drive_n(output_drive_n), .nv_lock_n(nv_lock_n), .host_out(line_out), .host_oe(line_oe),
        .line(line_in), .dev_oe(dev_oe));
    always #12.5 core_clk = ~core_clk;
    assign wdata = wbuf[widx[4:0]];
    // ========================================
    // Helpers
    function automatic logic [7:0] pat(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction : pat
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : chk8
    task automatic chk1(input logic got, input logic exp, input string msg);
        chk8({7'h00, got}, {7'h00, exp}, msg);
    endtask : chk1
    task automatic end_of_test();
        if (failures == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    always @(negedge core_clk) begin
        if (req_seen && !wdata_req) widx <= widx + 1;
        req_seen <= wdata_req;
        if (rdata_valid === 1'b1) rq.push_back(rdata);
        chk1((chip_select_n || write_strobe_n || output_drive_n) && !(line_oe && dev_oe), 1'b1, "line");
    end
    task automatic run(input logic [1:0] op, input logic [15:0] a, input logic [5:0] n);
        int k;
        @(negedge core_clk);
        rq = {};
        widx = 0;
        cmd_op = op;
        cmd_addr = a;
        cmd_len = n;
        cmd_valid = 1'b1;
        for (k = 0; k < 100 && cmd_ready !== 1'b1; k++) @(negedge core_clk);
        @(negedge core_clk);
        cmd_valid = 1'b0;
        @(negedge core_clk);
        for (k = 0; k < 20000 && cmd_ready !== 1'b1; k++) @(negedge core_clk);
        chk1(cmd_ready, 1'b1, "command done");
    endtask : run
    task automatic read_cmp(input logic [15:0] a, input int n, input int rot, input logic from_buf);
        run(2'h0, a, 6'(n));
        chk8(8'(rq.size()), 8'(n), "byte count");
        for (int j = 0; j < n && j < rq.size(); j++) begin
            chk8(rq[j], from_buf ? wbuf[(j + rot) % 32] : pat(a + 16'(j)), "read byte");
        end
    endtask : read_cmp
    task automatic poll_idle();
        for (int k = 0; k < 200; k++) begin
            run(2'h2, 16'h0000, 6'h01);
            if (busy_status === 1'b0) break;
        end
        chk1(busy_status, 1'b0, "program finished");
    endtask : poll_idle
    // ========================================
    // Scenarios
    task automatic t_program();
        for (int i = 0; i < 32; i++) wbuf[i] = 8'(i * 37 + 11);
        run(2'h1, 16'h0040, 6'h04);
        run(2'h2, 16'h0000, 6'h01);
        chk1(busy_status, 1'b1, "busy status");
        nv_lock_n = 1'b0;
        poll_idle();
        nv_lock_n = 1'b1;
        read_cmp(16'h0040, 4, 0, 1'b1);
    endtask : t_program
    task automatic t_page_wrap();
        for (int i = 0; i < 32; i++) wbuf[i] = 8'h80 + 8'(i);
        run(2'h1, 16'h005e, 6'h20);
        poll_idle();
        read_cmp(16'h0040, 32, 2, 1'b1);
    endtask : t_page_wrap
    task automatic t_locked();
        nv_lock_n = 1'b0;
        for (int i = 0; i < 32; i++) wbuf[i] = 8'h11;
        run(2'h1, 16'h0100, 6'h02);
        run(2'h2, 16'h0000, 6'h01);
        chk1(busy_status, 1'b0, "locked write");
        nv_lock_n = 1'b1;
        read_cmp(16'h0100, 2, 0, 1'b0);
    endtask : t_locked
    task automatic t_reads();
        read_cmp(16'hffff, 2, 0, 1'b0);
        read_cmp(16'h0200, 1, 0, 1'b0);
    endtask : t_reads
    initial begin
        for (int i = 0; i < 32; i++) wbuf[i] = 8'h00;
        repeat (10) @(negedge core_clk);
        rst = 1'b0;
        t_program();
        t_page_wrap();
        t_locked();
        t_reads();
        end_of_test();
    end
    initial begin
        #1000000;
        failures++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        end_of_test();
    end
endmodule : tb
`default_nettype wire
